// ---- rxb_backend.sv ----
// Overview of operation
// - Receive logic runs only while operating mode field equals 011.
// - IF gain field steps -13.5 dB to 0 dB by 4.5 dB; 0 dB after reset.
// - One bit picks low-pass (FSK) or complex polyphase (OOK) channel filter.
// - Signal strength value counts 0.5 dB per step.
// - OOK: strength sampled 16 times per second IF period.
// - FSK: strength sampled 16 times per deviation period.
// - Sliding 16-sample average refreshes the value on every new sample.
// - Value above alarm level raises the alarm condition.
// - Alarm status clears only on a written one; zero leaves it.
// - Two route bits send the alarm to pin a or pin b.
// - Deviation field sets estimator sampling rate; the data recovery is paced by the bit tick instead.
// - FSK demodulator outputs polarity from relative I/Q phase.
// - Continuous mode without recovery gives the raw demodulator output.
// - Continuous mode with recovery gives recovered clock and data.
// - Buffered mode writes only resynchronised data into the FIFO.
// - Recovery forced on in buffered and packet modes.
`timescale 1ns/1ps
`default_nettype none

module rxb_backend #(
  parameter int DEV_W = 8,
  parameter int STR_W = 8
) (
  input  wire logic             clk_in,
  input  wire logic             resetn_in,
  input  wire logic [2:0]       operating_mode_field_in,
  input  wire logic [1:0]       if_amplifier_gain_field_in,
  input  wire logic             complex_filter_enable_in,
  input  wire logic [DEV_W-1:0] deviation_field_in,
  input  wire logic [STR_W-1:0] strength_alarm_level_in,
  input  wire logic             strength_alarm_clear_in,
  input  wire logic             rx_alarm_route_pin_a_in,
  input  wire logic             rx_alarm_route_pin_b_in,
  input  wire logic [1:0]       data_mode_in,
  input  wire logic             recovery_disable_in,
  input  wire logic [STR_W-1:0] strength_sample_in,
  input  wire logic             i_sign_in,
  input  wire logic             q_sign_in,
  input  wire logic             bit_tick_in,
  output logic                  receive_active_out,
  output logic [1:0]            if_gain_setting_out,
  output logic                  polyphase_select_out,
  output logic                  strength_sample_tick_out,
  output logic [STR_W-1:0]      signal_strength_value_out,
  output logic                  strength_alarm_status_out,
  output logic                  interrupt_pin_a_out,
  output logic                  interrupt_pin_b_out,
  output logic                  raw_data_out,
  output logic                  recovered_clock_out,
  output logic                  recovered_data_out,
  output logic                  fifo_write_out,
  output logic                  fifo_data_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Mode decode.

  wire rx_on    = (operating_mode_field_in == rxb_pkg::RXB_MODE_RECEIVE);
  wire mode_c   = (data_mode_in == rxb_pkg::RXB_DATA_CONT);
  wire rec_on   = !mode_c || !recovery_disable_in;
  wire buffered = (data_mode_in == rxb_pkg::RXB_DATA_BUFF);
  // The spare data mode code acts like packet mode: recovery runs, but only
  // the retimed data registers see its result.

  ////////////////////////////////////////////////////////////////////////////
  // Sample pacing: one sample every (deviation+1) clocks, so the rate tracks
  // the programmed deviation. In OOK the host programs the second IF here.

  logic [DEV_W-1:0] pace_q;
  wire              pace_hit = (pace_q == deviation_field_in);
  wire              sample   = rx_on && pace_hit;

  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      pace_q <= '0;
    else if (!rx_on || pace_hit)
      pace_q <= '0;
    else
      pace_q <= pace_q + 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sixteen-entry sliding window with a running sum; one LSB is 0.5 dB.
  // The sum is wide enough for sixteen full-scale samples, so it never wraps.

  localparam int WP_W  = rxb_pkg::RXB_SAMPLE_LOG2;
  localparam int SUM_W = STR_W + WP_W;
  logic [STR_W-1:0] win_q [rxb_pkg::RXB_SAMPLES];
  logic [SUM_W-1:0] sum_q;
  logic [WP_W-1:0]  wp_q;
  wire  [SUM_W-1:0] sum_d = sum_q + SUM_W'(strength_sample_in)
                            - SUM_W'(win_q[wp_q]);
  wire  [STR_W-1:0] avg_d = sum_d[SUM_W-1:rxb_pkg::RXB_SAMPLE_LOG2];

  genvar g;
  generate
    for (g = 0; g < rxb_pkg::RXB_SAMPLES; g++)
    begin : g_win
      wire load_entry = sample && (wp_q == WP_W'(g));

      always_ff @(posedge clk_in or negedge resetn_in)
      begin
        if (!resetn_in)
          win_q[g] <= '0;
        else if (load_entry)
          win_q[g] <= strength_sample_in;
      end
    end
  endgenerate

  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      sum_q                     <= '0;
      wp_q                      <= '0;
      signal_strength_value_out <= STR_W'(rxb_pkg::RXB_LEVEL_RESET);
      strength_sample_tick_out  <= 1'b0;
    end
    else
    begin
      strength_sample_tick_out <= sample;
      if (sample)
      begin
        sum_q                     <= sum_d;
        wp_q                      <= wp_q + 1'b1;
        signal_strength_value_out <= avg_d;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Alarm: a crossing in the clear cycle wins, so no event is lost.
  // It compares the registered average, so it trails each sample by a clock.

  wire alarm_set = rx_on &&
                   (signal_strength_value_out > strength_alarm_level_in);

  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      strength_alarm_status_out <= 1'b0;
    else if (alarm_set)
      strength_alarm_status_out <= 1'b1;
    else if (strength_alarm_clear_in)
      strength_alarm_status_out <= 1'b0;
  end

  assign interrupt_pin_a_out = strength_alarm_status_out &&
                               rx_alarm_route_pin_a_in;
  assign interrupt_pin_b_out = strength_alarm_status_out &&
                               rx_alarm_route_pin_b_in;

  ////////////////////////////////////////////////////////////////////////////
  // Configuration fields. They pass through a register only so that these
  // outputs come straight from a flip-flop; the interrupt pins are gated by the route inputs.

  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      receive_active_out   <= 1'b0;
      if_gain_setting_out  <= rxb_pkg::RXB_GAIN_RESET;
      polyphase_select_out <= 1'b0;
    end
    else
    begin
      receive_active_out   <= rx_on;
      if_gain_setting_out  <= if_amplifier_gain_field_in;
      polyphase_select_out <= complex_filter_enable_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Demodulation and data paths. Recovery retimes the polarity on the bit
  // tick, so glitches between ticks never reach the FIFO; the raw path has
  // no such protection and suits hosts that recover the timing themselves.

  wire polarity     = i_sign_in ^ q_sign_in;
  wire retime       = rx_on && rec_on && bit_tick_in;
  wire raw_d        = rx_on && mode_c && !rec_on && polarity;
  wire rec_clock_d  = retime && mode_c;
  wire fifo_write_d = retime && buffered;

  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      raw_data_out        <= 1'b0;
      recovered_clock_out <= 1'b0;
      fifo_write_out      <= 1'b0;
    end
    else
    begin
      raw_data_out        <= raw_d;
      recovered_clock_out <= rec_clock_d;
      fifo_write_out      <= fifo_write_d;
    end
  end

  // Retimed data holds between ticks, so a reader may take it at any time
  // up to the next recovered clock or FIFO strobe.
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      recovered_data_out <= 1'b0;
      fifo_data_out      <= 1'b0;
    end
    else if (retime)
    begin
      recovered_data_out <= polarity;
      fifo_data_out      <= polarity;
    end
  end

endmodule

`default_nettype wire

// ---- rxb_backend_properties.sv ----
`timescale 1ns/1ps
`default_nettype none
module rxb_props (
  input wire logic       clk_in, resetn_in, complex_filter_enable_in,
  input wire logic       strength_alarm_clear_in, rx_alarm_route_pin_a_in,
  input wire logic       rx_alarm_route_pin_b_in, receive_active_out,
  input wire logic       polyphase_select_out, strength_alarm_status_out,
  input wire logic       interrupt_pin_a_out, interrupt_pin_b_out,
  input wire logic [2:0] operating_mode_field_in,
  input wire logic [1:0] if_amplifier_gain_field_in, if_gain_setting_out,
  input wire logic [7:0] strength_alarm_level_in, signal_strength_value_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!resetn_in);
  wire hit = (operating_mode_field_in == 3'h3) &&
    (signal_strength_value_out > strength_alarm_level_in);
  wire st = strength_alarm_status_out;
  property p_rx; $past(resetn_in) |-> receive_active_out ==
    ($past(operating_mode_field_in) == 3'h3); endproperty
  property p_gain; $past(resetn_in) |->
    if_gain_setting_out == $past(if_amplifier_gain_field_in); endproperty
  property p_poly; $past(resetn_in) |->
    polyphase_select_out == $past(complex_filter_enable_in); endproperty
  property p_set; hit |=> st; endproperty
  property p_quiet; !st && !hit |=> !st; endproperty
  property p_hold; st && !strength_alarm_clear_in |=> st; endproperty
  property p_clr; st && strength_alarm_clear_in && !hit |=> !st; endproperty
  property p_pa; interrupt_pin_a_out == (st && rx_alarm_route_pin_a_in);
  endproperty
  property p_pb; interrupt_pin_b_out == (st && rx_alarm_route_pin_b_in);
  endproperty
  a_rx: assert property (p_rx) else $error("receive flag wrong");
  a_gain: assert property (p_gain) else $error("gain wrong");
  a_poly: assert property (p_poly) else $error("filter wrong");
  a_set: assert property (p_set) else $error("alarm not set");
  a_quiet: assert property (p_quiet) else $error("alarm spurious");
  a_hold: assert property (p_hold) else $error("alarm lost");
  a_clr: assert property (p_clr) else $error("alarm not cleared");
  a_pa: assert property (p_pa) else $error("pin a wrong");
  a_pb: assert property (p_pb) else $error("pin b wrong");
  c_set: cover property ($rose(st));
  c_clr: cover property ($fell(st));
  c_pb: cover property (interrupt_pin_b_out);
endmodule
bind rxb_backend rxb_props u_props (.*);
`default_nettype wire

// ---- rxb_backend_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module rxb_backend_tb_top;
  logic clk_in, resetn_in, complex_filter_enable_in, strength_alarm_clear_in;
  logic rx_alarm_route_pin_a_in, rx_alarm_route_pin_b_in, recovery_disable_in;
  logic i_sign_in, q_sign_in, bit_tick_in, receive_active_out, pol_q, pq;
  logic polyphase_select_out, strength_sample_tick_out, raw_data_out;
  logic strength_alarm_status_out, interrupt_pin_a_out, interrupt_pin_b_out;
  logic recovered_clock_out, recovered_data_out, fifo_write_out, fifo_data_out;
  logic [2:0] operating_mode_field_in;
  logic [1:0] if_amplifier_gain_field_in, if_gain_setting_out, data_mode_in;
  logic [7:0] deviation_field_in, strength_alarm_level_in, strength_sample_in;
  logic [7:0] signal_strength_value_out, lvl;
  int         n_errors = 0, samples_checked = 0, cyc = 0;
  rxb_backend dut (.*);
  rxb_far_tx far (.clk_in(clk_in), .resetn_in(resetn_in), .level_in(lvl),
    .strength_sample_out(strength_sample_in), .i_sign_out(i_sign_in),
    .q_sign_out(q_sign_in), .bit_tick_out(bit_tick_in));
  task automatic check(input logic [7:0] seen, exp);
    samples_checked++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic final_report;
    $display("compares %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // Bounded wait, so a missing strobe shows up as a mismatch, not a hang.
  // The selector picks the sample tick (0), recovered clock (1) or FIFO
  // write (2).
  task automatic wait_hi(input int sel);
    logic s;
    s = 1'b0;
    for (int k = 0; k < 64 && s !== 1'b1; k++)
    begin
      @(negedge clk_in);
      s = (sel == 0) ? strength_sample_tick_out :
          (sel == 1) ? recovered_clock_out : fifo_write_out;
    end
    check(8'(s), 8'h1);
  endtask
  task automatic pulse_clear;
    @(posedge clk_in);
    strength_alarm_clear_in <= 1'b1;
    @(posedge clk_in);
    strength_alarm_clear_in <= 1'b0;
    @(negedge clk_in);
  endtask
  initial
  begin
    clk_in = 1'b0;
    forever #2 clk_in = ~clk_in;
  end
  always @(posedge clk_in)
  begin
    cyc <= cyc + 1;
    pq <= i_sign_in ^ q_sign_in;
    if (bit_tick_in)
      pol_q <= i_sign_in ^ q_sign_in;
    if (cyc == 2000)
    begin
      n_errors++;
      final_report;
    end
  end
  initial
  begin
    {resetn_in, complex_filter_enable_in, strength_alarm_clear_in,
      rx_alarm_route_pin_a_in, rx_alarm_route_pin_b_in, recovery_disable_in,
      if_amplifier_gain_field_in, data_mode_in, strength_alarm_level_in} <= '0;
    operating_mode_field_in <= 3'h1;
    deviation_field_in <= 8'h03;
    lvl <= 8'h40;
    repeat (8) @(posedge clk_in);
    resetn_in <= 1'b1;
    for (int g = 0; g < 4; g++)
    begin
      @(posedge clk_in);
      if_amplifier_gain_field_in <= 2'(g);
      complex_filter_enable_in <= g[0];
      repeat (2) @(negedge clk_in);
      check(8'(if_gain_setting_out), 8'(g));
      check(8'(polyphase_select_out), 8'(g[0]));
      check(signal_strength_value_out, 8'h00);
      check(8'(receive_active_out), 8'h0);
    end
    $display("test filters done");
    @(posedge clk_in);
    operating_mode_field_in <= 3'h3;
    wait_hi(0);
    check(8'(receive_active_out), 8'h1);
    check(signal_strength_value_out, 8'h04);
    repeat (4) @(negedge clk_in);
    check(8'(strength_sample_tick_out), 8'h1);
    repeat (60) @(negedge clk_in);
    check(signal_strength_value_out, 8'h40);
    $display("test strength done");
    @(posedge clk_in);
    strength_alarm_level_in <= 8'h40;
    rx_alarm_route_pin_a_in <= 1'b1;
    pulse_clear;
    check(8'(strength_alarm_status_out), 8'h0);
    @(posedge clk_in);
    strength_alarm_level_in <= 8'h3f;
    repeat (3) @(negedge clk_in);
    check(8'(interrupt_pin_a_out), 8'h1);
    @(posedge clk_in);
    strength_alarm_level_in <= 8'h40;
    {rx_alarm_route_pin_a_in, rx_alarm_route_pin_b_in} <= 2'h1;
    repeat (8) @(negedge clk_in);
    check(8'({interrupt_pin_a_out, interrupt_pin_b_out}), 8'h1);
    pulse_clear;
    check(8'(interrupt_pin_b_out), 8'h0);
    $display("test alarm done");
    @(posedge clk_in);
    recovery_disable_in <= 1'b1;
    // The first edge still sees recovery on, so its raw output is not valid.
    @(negedge clk_in);
    repeat (24) @(negedge clk_in)
      check(8'(raw_data_out), 8'(pq));
    @(posedge clk_in);
    recovery_disable_in <= 1'b0;
    wait_hi(1);
    check(8'(recovered_data_out), 8'(pol_q));
    @(posedge clk_in);
    {data_mode_in, recovery_disable_in} <= 3'h3;
    wait_hi(2);
    check(8'(fifo_data_out), 8'(pol_q));
    check(8'(raw_data_out), 8'h0);
    $display("test data done");
    final_report;
  end
endmodule
`default_nettype wire

// ---- rxb_far_tx.sv ----
`timescale 1ns/1ps
`default_nettype none
module rxb_far_tx (
  input  wire logic       clk_in, resetn_in,
  input  wire logic [7:0] level_in,
  output logic [7:0]      strength_sample_out,
  output logic            i_sign_out, q_sign_out, bit_tick_out
);
  logic [3:0] cnt_q;
  assign strength_sample_out = level_in;
  // A bit lasts 16 clocks, long against the sample pacing, so index >= 2.
  always_ff @(posedge clk_in or negedge resetn_in)
    if (!resetn_in)
      {cnt_q, i_sign_out, q_sign_out, bit_tick_out} <= '0;
    else
    begin
      cnt_q <= cnt_q + 4'h1;
      bit_tick_out <= (cnt_q == 4'hf);
      i_sign_out <= i_sign_out ^ (cnt_q == 4'hf);
      q_sign_out <= cnt_q[3];
    end
endmodule
`default_nettype wire

// ---- rxb_pkg.sv ----
package rxb_pkg;

  localparam logic [2:0] RXB_MODE_RECEIVE = 3'h3;
  localparam logic [1:0] RXB_GAIN_RESET   = 2'h0;
  localparam logic [1:0] RXB_DATA_CONT    = 2'h0;
  localparam logic [1:0] RXB_DATA_BUFF    = 2'h1;
  localparam logic [1:0] RXB_DATA_PACKET  = 2'h2;
  localparam int         RXB_SAMPLES      = 16;
  localparam int         RXB_SAMPLE_LOG2  = 4;
  localparam logic [7:0] RXB_DEV_RESET    = 8'h03;
  localparam logic [7:0] RXB_LEVEL_RESET  = 8'h00;

endpackage
